// File: lgas_top.sv
// Link group alignment status bank with a classic Wishbone slave.
// Assumes all event inputs come from logic on clk_in, so no
// synchronisers stand in front of them.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module lgas_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [lgas_pkg::LGAS_ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [lgas_pkg::LGAS_DAT_W-1:0] wb_dat_in,
  output logic [lgas_pkg::LGAS_DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [4:0] celldrop_evt_in,
  input wire logic [6:0] unaligned_evt_in,
  input wire logic [4:0] misalign_evt_in,
  input wire logic [lgas_pkg::LGAS_LINKS-1:0] fifo_wr_zero_in,
  input wire logic [lgas_pkg::LGAS_LINKS*lgas_pkg::LGAS_PTR_W-1:0]
    fifo_rd_ptr_in,
  output logic sonet_mode_out,
  output logic irq_out
);
  import lgas_pkg::*;

  // Register map, word indices on the bus; the byte address is four times.
  //   Cell drop status: read-only, bits 7 to 3 defined.
  //   Unaligned status: read-only, bits 7 to 1 defined.
  //   Near-full status: read-only, bits 7 to 1 defined.
  //   Bundle misalign status: read-only, bits 7 to 3 defined.
  //   Control: bit 0 selects SONET mode when set.
  //   FIFO minimum: four-bit near-full threshold.
  //   Event clear: write-only, one byte lane per status register.
  //   Event enable: read and write, same layout as the clear word.
  // Reads of the clear word and of unmapped indices return zero, and
  // writes to unmapped indices or to the status words change nothing. Every access
  // gets an ack, so a stray address never stalls the master.

  // Word match on a byte address; the low two bits are ignored.
  function automatic logic lgas_hit(
    input logic [LGAS_ADR_W-1:0] adr,
    input logic [LGAS_ADR_W-1:0] base
  );
    lgas_hit = (adr[LGAS_ADR_W-1:2] == base[LGAS_ADR_W-1:2]);
  endfunction : lgas_hit

  // Bus state.
  logic ack_reg;
  logic [LGAS_DAT_W-1:0] rdata_reg;
  logic bus_req;
  logic wr_go;
  logic rd_go;

  // Software state.
  lgas_mode_t mode_reg;
  logic [LGAS_PTR_W-1:0] fifo_min_reg;
  logic [31:0] en_reg;
  logic [31:0] stat_reg;
  logic [31:0] stat_next;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] valid_mask;
  logic irq_reg;

  // Per-byte write mask from the lane selects.
  logic [31:0] lane_mask;

  // Grouped near-full events from the watcher.
  logic [7:0] near;
  logic nf_pair_a_lo;
  logic nf_pair_a_hi;
  logic nf_pair_b_lo;
  logic nf_pair_b_hi;
  logic nf_quad_a;
  logic nf_quad_b;
  logic nf_all;

  // Mode qualifiers for event capture.
  logic cell_on;
  logic sonet_on;

  lgas_fifo_if fifo_bus ();

  // The watcher registers its compare, so near-full status lands one
  // cycle later than the other event groups.
  // Hand the FIFO view and threshold to the watcher.
  assign fifo_bus.wr_zero = fifo_wr_zero_in;
  assign fifo_bus.rd_ptr = fifo_rd_ptr_in;
  assign fifo_bus.min_level = fifo_min_reg;
  assign near = fifo_bus.near;

  lgas_fifo_watch u_watch (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .fw(fifo_bus.watcher)
  );

  // Bus timing: the request is seen on one edge, ack rises after it and
  // stands for one cycle. Reads capture on the seeing edge, so the data
  // is ready at the edge where the master samples ack. Writes wait for
  // the ack edge itself, which is where the master expects them to land.
  // A master that drops the strobe early therefore writes nothing.
  // Bus request decode. A write lands on the edge where ack is seen.
  assign bus_req = wb_cyc_in & wb_stb_in;
  assign wr_go = bus_req & wb_we_in & ack_reg;
  assign rd_go = bus_req & ~wb_we_in & ~ack_reg;

  // Expand the byte selects into a bit mask.
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign lane_mask[b*8 +: 8] = {8{wb_sel_in[b]}};
    end
  endgenerate

  // Ack one cycle after the request is seen and drop it the next.
  // Unmapped addresses are acknowledged too, so no master can hang.
  // Ack comes from a flop, so it never glitches while the address
  // decode settles.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  // Read data is captured with the ack and stands while it is high.
  // Reserved bits zero.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= '0;
    end else if (rd_go) begin
      rdata_reg <= '0;
      if (lgas_hit(wb_adr_in, LGAS_ADDR_CELLDROP)) begin
        rdata_reg[7:0] <= stat_reg[LGAS_LANE_CELLDROP*8 +: 8] &
          LGAS_CELL_MASK;
      end else if (lgas_hit(wb_adr_in, LGAS_ADDR_UNALIGNED)) begin
        rdata_reg[7:0] <= stat_reg[LGAS_LANE_UNALIGNED*8 +: 8] &
          LGAS_SONET_MASK;
      end else if (lgas_hit(wb_adr_in, LGAS_ADDR_NEARFULL)) begin
        rdata_reg[7:0] <= stat_reg[LGAS_LANE_NEARFULL*8 +: 8] &
          LGAS_SONET_MASK;
      end else if (lgas_hit(wb_adr_in, LGAS_ADDR_MISALIGN)) begin
        rdata_reg[7:0] <= stat_reg[LGAS_LANE_MISALIGN*8 +: 8] &
          LGAS_CELL_MASK;
      end else if (lgas_hit(wb_adr_in, LGAS_ADDR_CTRL)) begin
        rdata_reg[LGAS_CTRL_MODE_BIT] <= mode_reg;
      end else if (lgas_hit(wb_adr_in, LGAS_ADDR_FIFO_MIN)) begin
        rdata_reg[LGAS_PTR_W-1:0] <= fifo_min_reg;
      end else if (lgas_hit(wb_adr_in, LGAS_ADDR_EVT_EN)) begin
        rdata_reg <= en_reg & valid_mask;
      end
    end else begin
      // Back to zero on the ack edge, so the bus idles at zero.
      rdata_reg <= '0;
    end
  end

  // Mode control: cell mode after reset.
  // A mode switch leaves the status words as they are.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_reg <= LGAS_MODE_CELL;
    end else if (wr_go && wb_sel_in[0] &&
                 lgas_hit(wb_adr_in, LGAS_ADDR_CTRL)) begin
      mode_reg <= lgas_mode_t'(wb_dat_in[LGAS_CTRL_MODE_BIT]);
    end
  end

  // Receive FIFO minimum level used by the near-full compare.
  // A threshold of zero can never trip, since no pointer is below it.
  // Programmed threshold.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fifo_min_reg <= LGAS_FIFO_MIN_RST;
    end else if (wr_go && wb_sel_in[0] &&
                 lgas_hit(wb_adr_in, LGAS_ADDR_FIFO_MIN)) begin
      fifo_min_reg <= wb_dat_in[LGAS_PTR_W-1:0];
    end
  end

  // Interrupt enables share the status layout; byte lanes apply.
  // Reserved enables ignored.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      en_reg <= LGAS_EN_RST;
    end else if (wr_go && lgas_hit(wb_adr_in, LGAS_ADDR_EVT_EN)) begin
      en_reg <= ((en_reg & ~lane_mask) | (wb_dat_in & lane_mask)) &
        valid_mask;
    end
  end

  // Only defined status bits may ever hold a one.
  // The same mask guards the status and enable words, which keeps the
  // reserved positions at zero whatever software writes.
  assign valid_mask = {LGAS_CELL_MASK, LGAS_SONET_MASK,
                       LGAS_SONET_MASK, LGAS_CELL_MASK};

  // Mode gating sits here rather than at the inputs: the alignment
  // logic may keep pulsing events of the idle mode, and they must not
  // leave sticky bits that software would misread after a mode switch.
  // Bits already set survive a switch until software clears them.
  // Mode qualifiers: events of the other mode are not recorded.
  assign cell_on = (mode_reg == LGAS_MODE_CELL);
  assign sonet_on = (mode_reg == LGAS_MODE_SONET);

  // A pair, quad or eight-link bit is the OR of its member links; the
  // status does not say which link of a group tripped, so software
  // that needs the link must look at the pointers itself.
  // Near-full grouping over the per-link pulses.
  // Links 0..3 are AA, AB, AC, AD and 4..7 are BA, BB, BC, BD.
  // Block A and B pairs, then the two quads and the all-link OR.
  assign nf_pair_a_lo = near[0] | near[1];
  assign nf_pair_a_hi = near[2] | near[3];
  assign nf_pair_b_lo = near[4] | near[5];
  assign nf_pair_b_hi = near[6] | near[7];
  assign nf_quad_a = |near[3:0];
  assign nf_quad_b = |near[7:4];
  assign nf_all = |near;

  // Assemble the set vector, one byte per status register.
  always_comb begin
    set_vec = '0;
    set_vec[LGAS_LANE_CELLDROP*8 + LGAS_CB_PAIR_B_HI] =
      cell_on & celldrop_evt_in[LGAS_CE_PAIR_B_HI];
    set_vec[LGAS_LANE_CELLDROP*8 + LGAS_CB_PAIR_B_LO] =
      cell_on & celldrop_evt_in[LGAS_CE_PAIR_B_LO];
    set_vec[LGAS_LANE_CELLDROP*8 + LGAS_CB_PAIR_A_HI] =
      cell_on & celldrop_evt_in[LGAS_CE_PAIR_A_HI];
    set_vec[LGAS_LANE_CELLDROP*8 + LGAS_CB_PAIR_A_LO] =
      cell_on & celldrop_evt_in[LGAS_CE_PAIR_A_LO];
    set_vec[LGAS_LANE_CELLDROP*8 + LGAS_CB_ALL] =
      cell_on & celldrop_evt_in[LGAS_CE_ALL];
    set_vec[LGAS_LANE_UNALIGNED*8 + LGAS_SB_QUAD_B] =
      sonet_on & unaligned_evt_in[LGAS_SE_QUAD_B];
    set_vec[LGAS_LANE_UNALIGNED*8 + LGAS_SB_PAIR_B_HI] =
      sonet_on & unaligned_evt_in[LGAS_SE_PAIR_B_HI];
    set_vec[LGAS_LANE_UNALIGNED*8 + LGAS_SB_PAIR_B_LO] =
      sonet_on & unaligned_evt_in[LGAS_SE_PAIR_B_LO];
    set_vec[LGAS_LANE_UNALIGNED*8 + LGAS_SB_QUAD_A] =
      sonet_on & unaligned_evt_in[LGAS_SE_QUAD_A];
    set_vec[LGAS_LANE_UNALIGNED*8 + LGAS_SB_PAIR_A_HI] =
      sonet_on & unaligned_evt_in[LGAS_SE_PAIR_A_HI];
    set_vec[LGAS_LANE_UNALIGNED*8 + LGAS_SB_PAIR_A_LO] =
      sonet_on & unaligned_evt_in[LGAS_SE_PAIR_A_LO];
    set_vec[LGAS_LANE_UNALIGNED*8 + LGAS_SB_ALL] =
      sonet_on & unaligned_evt_in[LGAS_SE_ALL];
    set_vec[LGAS_LANE_NEARFULL*8 + LGAS_SB_QUAD_B] = sonet_on & nf_quad_b;
    set_vec[LGAS_LANE_NEARFULL*8 + LGAS_SB_PAIR_B_HI] =
      sonet_on & nf_pair_b_hi;
    set_vec[LGAS_LANE_NEARFULL*8 + LGAS_SB_PAIR_B_LO] =
      sonet_on & nf_pair_b_lo;
    set_vec[LGAS_LANE_NEARFULL*8 + LGAS_SB_QUAD_A] = sonet_on & nf_quad_a;
    set_vec[LGAS_LANE_NEARFULL*8 + LGAS_SB_PAIR_A_HI] =
      sonet_on & nf_pair_a_hi;
    set_vec[LGAS_LANE_NEARFULL*8 + LGAS_SB_PAIR_A_LO] =
      sonet_on & nf_pair_a_lo;
    set_vec[LGAS_LANE_NEARFULL*8 + LGAS_SB_ALL] = sonet_on & nf_all;
    set_vec[LGAS_LANE_MISALIGN*8 + LGAS_CB_PAIR_B_HI] =
      cell_on & misalign_evt_in[LGAS_CE_PAIR_B_HI];
    set_vec[LGAS_LANE_MISALIGN*8 + LGAS_CB_PAIR_B_LO] =
      cell_on & misalign_evt_in[LGAS_CE_PAIR_B_LO];
    set_vec[LGAS_LANE_MISALIGN*8 + LGAS_CB_PAIR_A_HI] =
      cell_on & misalign_evt_in[LGAS_CE_PAIR_A_HI];
    set_vec[LGAS_LANE_MISALIGN*8 + LGAS_CB_PAIR_A_LO] =
      cell_on & misalign_evt_in[LGAS_CE_PAIR_A_LO];
    set_vec[LGAS_LANE_MISALIGN*8 + LGAS_CB_ALL] =
      cell_on & misalign_evt_in[LGAS_CE_ALL];
  end

  // Byte lanes mask the clear word, so a narrow write clears only the
  // status registers whose lane it selects.
  // Clear pulses come from writes to the write-only clear word.
  assign clr_vec = (wr_go && lgas_hit(wb_adr_in, LGAS_ADDR_EVT_CLR)) ?
    (wb_dat_in & lane_mask) : 32'h0000_0000;

  // Sticky status: a set in the same cycle as a clear wins, so an event
  // landing on a software clear is never lost.
  // Status is read-only.
  assign stat_next = ((stat_reg & ~clr_vec) | set_vec) & valid_mask;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      stat_reg <= {4{LGAS_STAT_RST}};
    end else begin
      stat_reg <= stat_next;
    end
  end

  // The extra cycle of latency buys a glitch-free pin, since the enable
  // and status words meet in logic before a flop.
  // Level interrupt; registered, so it trails the status by one cycle.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & en_reg);
    end
  end

  // Port drive.
  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdata_reg;
  assign irq_out = irq_reg;
  assign sonet_mode_out = mode_reg;
endmodule : lgas_top
`default_nettype wire

// File: lgas_pkg.sv
// Constants for the link group alignment status register bank.
// Assumes a 32-bit classic Wishbone bus with byte addresses on 20 bits.
package lgas_pkg;

  // Bus shape.
  localparam int LGAS_ADR_W = 20;
  localparam int LGAS_DAT_W = 32;

  // Link count and receive FIFO address width.
  localparam int LGAS_LINKS = 8;
  localparam int LGAS_PTR_W = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [LGAS_ADR_W-1:0] LGAS_IDX_CELLDROP = 20'h30A0B;
  localparam logic [LGAS_ADR_W-1:0] LGAS_IDX_UNALIGNED = 20'h30A0C;
  localparam logic [LGAS_ADR_W-1:0] LGAS_IDX_NEARFULL = 20'h30A0D;
  localparam logic [LGAS_ADR_W-1:0] LGAS_IDX_MISALIGN = 20'h30A0E;
  localparam logic [LGAS_ADR_W-1:0] LGAS_IDX_CTRL = 20'h30A10;
  localparam logic [LGAS_ADR_W-1:0] LGAS_IDX_FIFO_MIN = 20'h30A11;
  localparam logic [LGAS_ADR_W-1:0] LGAS_IDX_EVT_CLR = 20'h30A12;
  localparam logic [LGAS_ADR_W-1:0] LGAS_IDX_EVT_EN = 20'h30A13;

  // Byte addresses derived from the indices.
  localparam logic [LGAS_ADR_W-1:0] LGAS_ADDR_CELLDROP = 20'h30A0B << 2;
  localparam logic [LGAS_ADR_W-1:0] LGAS_ADDR_UNALIGNED = 20'h30A0C << 2;
  localparam logic [LGAS_ADR_W-1:0] LGAS_ADDR_NEARFULL = 20'h30A0D << 2;
  localparam logic [LGAS_ADR_W-1:0] LGAS_ADDR_MISALIGN = 20'h30A0E << 2;
  localparam logic [LGAS_ADR_W-1:0] LGAS_ADDR_CTRL = 20'h30A10 << 2;
  localparam logic [LGAS_ADR_W-1:0] LGAS_ADDR_FIFO_MIN = 20'h30A11 << 2;
  localparam logic [LGAS_ADR_W-1:0] LGAS_ADDR_EVT_CLR = 20'h30A12 << 2;
  localparam logic [LGAS_ADR_W-1:0] LGAS_ADDR_EVT_EN = 20'h30A13 << 2;

  // Byte lanes of the combined status, clear and enable words.
  localparam int LGAS_LANE_CELLDROP = 0;
  localparam int LGAS_LANE_UNALIGNED = 1;
  localparam int LGAS_LANE_NEARFULL = 2;
  localparam int LGAS_LANE_MISALIGN = 3;

  // Bit positions in the cell drop and bundle misalign registers.
  localparam int LGAS_CB_PAIR_B_HI = 3;
  localparam int LGAS_CB_PAIR_B_LO = 4;
  localparam int LGAS_CB_PAIR_A_HI = 5;
  localparam int LGAS_CB_PAIR_A_LO = 6;
  localparam int LGAS_CB_ALL = 7;

  // Bit positions in the unaligned and near-full registers.
  localparam int LGAS_SB_QUAD_B = 1;
  localparam int LGAS_SB_PAIR_B_HI = 2;
  localparam int LGAS_SB_PAIR_B_LO = 3;
  localparam int LGAS_SB_QUAD_A = 4;
  localparam int LGAS_SB_PAIR_A_HI = 5;
  localparam int LGAS_SB_PAIR_A_LO = 6;
  localparam int LGAS_SB_ALL = 7;

  // Event input vectors: index of each group.
  localparam int LGAS_CE_PAIR_B_HI = 0;
  localparam int LGAS_CE_PAIR_B_LO = 1;
  localparam int LGAS_CE_PAIR_A_HI = 2;
  localparam int LGAS_CE_PAIR_A_LO = 3;
  localparam int LGAS_CE_ALL = 4;
  localparam int LGAS_SE_QUAD_B = 0;
  localparam int LGAS_SE_PAIR_B_HI = 1;
  localparam int LGAS_SE_PAIR_B_LO = 2;
  localparam int LGAS_SE_QUAD_A = 3;
  localparam int LGAS_SE_PAIR_A_HI = 4;
  localparam int LGAS_SE_PAIR_A_LO = 5;
  localparam int LGAS_SE_ALL = 6;

  // Defined bits of each status byte; everything else reads zero.
  localparam logic [7:0] LGAS_CELL_MASK = 8'hF8;
  localparam logic [7:0] LGAS_SONET_MASK = 8'hFE;

  // Control register fields and reset values.
  localparam int LGAS_CTRL_MODE_BIT = 0;
  localparam logic [7:0] LGAS_STAT_RST = 8'h00;
  localparam logic [31:0] LGAS_EN_RST = 32'h0000_0000;
  localparam logic [LGAS_PTR_W-1:0] LGAS_FIFO_MIN_RST = 4'h4;

  typedef enum logic {
    LGAS_MODE_CELL = 1'b0,
    LGAS_MODE_SONET = 1'b1
  } lgas_mode_t;

endpackage : lgas_pkg

// File: lgas_fifo_if.sv
// Carrier between the register bank and the FIFO near-full watcher.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface lgas_fifo_if;
  import lgas_pkg::*;

  logic [LGAS_LINKS-1:0] wr_zero;
  logic [LGAS_LINKS*LGAS_PTR_W-1:0] rd_ptr;
  logic [LGAS_PTR_W-1:0] min_level;
  logic [LGAS_LINKS-1:0] near;

  modport watcher (input wr_zero, input rd_ptr, input min_level,
    output near);
  modport core (output wr_zero, output rd_ptr, output min_level,
    input near);
endinterface : lgas_fifo_if
`default_nettype wire

// File: lgas_fifo_watch.sv
// Per-link near-full detector for the receive alignment FIFOs.
// Assumes write-to-location-zero strobes and read pointers on clk_in.
`timescale 1ns/10ps
`default_nettype none
module lgas_fifo_watch (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  lgas_fifo_if.watcher fw
);
  import lgas_pkg::*;

  logic [LGAS_LINKS-1:0] near_reg;

  // One detector per link; a pulse marks a near-full sample.
  genvar i;
  generate
    for (i = 0; i < LGAS_LINKS; i++) begin : g_link
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          near_reg[i] <= 1'b0;
        end else begin
          near_reg[i] <= fw.wr_zero[i] &&
            (fw.rd_ptr[i*LGAS_PTR_W +: LGAS_PTR_W] < fw.min_level);
        end
      end
    end
  endgenerate

  // The result leaves as registered one-cycle pulses.
  assign fw.near = near_reg;
endmodule : lgas_fifo_watch
`default_nettype wire

// File: lgas_top_sva.sv
// Checker for the link group alignment status bank, ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module lgas_top_sva (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [lgas_pkg::LGAS_ADR_W-1:0] wb_adr_in,
  input wire logic [lgas_pkg::LGAS_DAT_W-1:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic sonet_mode_out,
  input wire logic irq_out
);
  import lgas_pkg::*;

  // Register index and read-answer helpers; low address bits are ignored.
  logic [17:0] idx;
  logic rd_ack;
  logic mapped;
  assign idx = wb_adr_in[19:2];
  assign rd_ack = wb_ack_out && !wb_we_in;
  assign mapped = idx inside {LGAS_IDX_CELLDROP[17:0],
    LGAS_IDX_UNALIGNED[17:0], LGAS_IDX_NEARFULL[17:0],
    LGAS_IDX_MISALIGN[17:0], LGAS_IDX_CTRL[17:0],
    LGAS_IDX_FIFO_MIN[17:0], LGAS_IDX_EVT_CLR[17:0],
    LGAS_IDX_EVT_EN[17:0]};

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // A fresh request, then a single-cycle acknowledge.
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence

  property p_ack_resp;
    s_req |=> s_pulse;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("ack did not follow a request as one pulse");

  property p_ack_cause;
    $rose(wb_ack_out) |-> $past(wb_cyc_in) && $past(wb_stb_in);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack rose without a request");

  property p_idle_zero;
    !wb_ack_out |-> wb_dat_out == '0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not zero outside an answer");

  property p_cell_rsvd;
    rd_ack && (idx == LGAS_IDX_CELLDROP[17:0] ||
      idx == LGAS_IDX_MISALIGN[17:0]) |->
      (wb_dat_out & ~{24'h0, LGAS_CELL_MASK}) == '0;
  endproperty
  a_cell_rsvd: assert property (p_cell_rsvd)
    else $error("reserved cell status bits read nonzero");

  property p_sonet_rsvd;
    rd_ack && (idx == LGAS_IDX_UNALIGNED[17:0] ||
      idx == LGAS_IDX_NEARFULL[17:0]) |->
      (wb_dat_out & ~{24'h0, LGAS_SONET_MASK}) == '0;
  endproperty
  a_sonet_rsvd: assert property (p_sonet_rsvd)
    else $error("reserved sonet status bits read nonzero");

  property p_clr_zero;
    rd_ack && idx == LGAS_IDX_EVT_CLR[17:0] |-> wb_dat_out == '0;
  endproperty
  a_clr_zero: assert property (p_clr_zero)
    else $error("clear register read nonzero");

  property p_unmapped;
    rd_ack && !mapped |-> wb_dat_out == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read nonzero");

  // Mode only moves on a completed write.
  property p_mode_cause;
    $changed(sonet_mode_out) |-> $past(wb_ack_out) && $past(wb_we_in);
  endproperty
  a_mode_cause: assert property (p_mode_cause)
    else $error("mode changed without a write");

  property p_irq_fall;
    $fell(irq_out) |-> $past(wb_ack_out, 2) || $past(wb_ack_out, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without a write");
endmodule : lgas_top_sva
`default_nettype wire

// File: test_lgas_top.sv
// Self-checking bench for the link group alignment status bank.
// Assumes the bank answers every Wishbone request after one cycle.
`timescale 1ns/10ps
`default_nettype none
module test_lgas_top;
  import lgas_pkg::*;

  logic clk_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [19:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, fifo_rd_ptr_in;
  logic wb_ack_out, sonet_mode_out, irq_out;
  logic [4:0] celldrop_evt_in, misalign_evt_in;
  logic [6:0] unaligned_evt_in;
  logic [7:0] fifo_wr_zero_in;
  int err_total = 0;
  int checks = 0;

  lgas_top uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .celldrop_evt_in(celldrop_evt_in), .unaligned_evt_in(unaligned_evt_in),
    .misalign_evt_in(misalign_evt_in), .fifo_wr_zero_in(fifo_wr_zero_in),
    .fifo_rd_ptr_in(fifo_rd_ptr_in), .sonet_mode_out(sonet_mode_out),
    .irq_out(irq_out));

  // Free-running 125 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic end_of_test();
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; a missing ack is cut short after 16 edges.
  task automatic bus(input logic w, input logic [19:0] idx,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= idx << 2;
    wb_dat_in <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 16);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
    if (n >= 16) begin
      err_total++;
      end_of_test();
    end
  endtask : bus

  task automatic wr(input logic [19:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [19:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    chk(q, exp);
  endtask : rd

  // One-cycle event pulse: 0 cell drop, 1 unaligned, 2 misalign, 3 FIFO.
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge clk_in);
    case (k)
      0: celldrop_evt_in <= v[4:0];
      1: unaligned_evt_in <= v[6:0];
      2: misalign_evt_in <= v[4:0];
      default: fifo_wr_zero_in <= v;
    endcase
    @(posedge clk_in);
    celldrop_evt_in <= 5'h00;
    unaligned_evt_in <= 7'h00;
    misalign_evt_in <= 5'h00;
    fifo_wr_zero_in <= 8'h00;
  endtask : pulse

  // reset values of the status bytes and the FIFO minimum.
  task automatic t_reset();
    rd(LGAS_IDX_CELLDROP, 32'h0);
    rd(LGAS_IDX_UNALIGNED, 32'h0);
    rd(LGAS_IDX_NEARFULL, 32'h0);
    rd(LGAS_IDX_MISALIGN, 32'h0);
    rd(LGAS_IDX_FIFO_MIN, {28'h0, LGAS_FIFO_MIN_RST});
  endtask : t_reset

  // cell events accumulate; sonet events are dropped.
  task automatic t_cell();
    logic [31:0] acc;
    acc = 32'h0;
    for (int i = 0; i < 5; i++) begin
      pulse(0, 8'h01 << i);
      pulse(2, 8'h01 << i);
      acc = acc | (32'h8 << i);
      rd(LGAS_IDX_CELLDROP, acc);
      rd(LGAS_IDX_MISALIGN, acc);
    end
    pulse(1, 8'h7F);
    pulse(3, 8'hFF);
    rd(LGAS_IDX_UNALIGNED, 32'h0);
    rd(LGAS_IDX_NEARFULL, 32'h0);
    wr(LGAS_IDX_CELLDROP, 32'h0000_00FF);
    rd(LGAS_IDX_CELLDROP, 32'hF8);
    wr(LGAS_IDX_EVT_CLR, 32'hFFFF_FFFF);
    rd(LGAS_IDX_CELLDROP, 32'h0);
    rd(LGAS_IDX_MISALIGN, 32'h0);
  endtask : t_cell

  // every unaligned group in sonet mode.
  task automatic t_sonet();
    logic [31:0] acc;
    acc = 32'h0;
    wr(LGAS_IDX_CTRL, 32'h1);
    @(posedge clk_in);
    chk({31'h0, sonet_mode_out}, 32'h1);
    for (int i = 0; i < 7; i++) begin
      pulse(1, 8'h01 << i);
      acc = acc | (32'h2 << i);
      rd(LGAS_IDX_UNALIGNED, acc);
    end
    pulse(0, 8'h1F);
    pulse(2, 8'h1F);
    rd(LGAS_IDX_CELLDROP, 32'h0);
    rd(LGAS_IDX_MISALIGN, 32'h0);
    wr(LGAS_IDX_EVT_CLR, 32'h0000_FF00);
    rd(LGAS_IDX_UNALIGNED, 32'h0);
  endtask : t_sonet

  // near-full per link, with the threshold boundary.
  task automatic t_near();
    int pb[4];
    logic [31:0] exp;
    pb = '{LGAS_SB_PAIR_A_LO, LGAS_SB_PAIR_A_HI, LGAS_SB_PAIR_B_LO,
      LGAS_SB_PAIR_B_HI};
    wr(LGAS_IDX_FIFO_MIN, 32'h5);
    rd(LGAS_IDX_FIFO_MIN, 32'h5);
    fifo_rd_ptr_in <= {8{4'h5}};
    pulse(3, 8'hFF);
    rd(LGAS_IDX_NEARFULL, 32'h0);
    fifo_rd_ptr_in <= {8{4'h4}};
    for (int i = 0; i < 8; i++) begin
      pulse(3, 8'h01 << i);
      exp = (32'h1 << LGAS_SB_ALL) | (32'h1 << pb[i / 2]) |
        (32'h1 << (i < 4 ? LGAS_SB_QUAD_A : LGAS_SB_QUAD_B));
      rd(LGAS_IDX_NEARFULL, exp);
      wr(LGAS_IDX_EVT_CLR, 32'h00FF_0000);
    end
  endtask : t_near

  // interrupt raised, masked, enabled late and cleared.
  task automatic t_irq();
    wr(LGAS_IDX_CTRL, 32'h0);
    wr(LGAS_IDX_EVT_EN, 32'h0000_0008);
    rd(LGAS_IDX_EVT_EN, 32'h8);
    pulse(0, 8'h02);
    repeat (3) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    pulse(0, 8'h01);
    repeat (3) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    wr(LGAS_IDX_EVT_CLR, 32'h0000_0008);
    repeat (3) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    wr(LGAS_IDX_EVT_EN, 32'h0000_0010);
    repeat (3) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    wr(LGAS_IDX_EVT_EN, 32'h0);
    repeat (3) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    // Lane 0 left out: only the upper three enable bytes may change.
    wb_sel_in <= 4'hE;
    wr(LGAS_IDX_EVT_EN, 32'hFFFF_FFFF);
    wb_sel_in <= 4'hF;
    rd(LGAS_IDX_EVT_EN, {LGAS_CELL_MASK, LGAS_SONET_MASK, LGAS_SONET_MASK,
      8'h00});
    rd(20'h30A0F, 32'h0);
    rd(LGAS_IDX_EVT_CLR, 32'h0);
  endtask : t_irq

  // Reset for 12 cycles, then the scenarios in turn.
  initial begin
    sys_rst_in = 1'b1;
    wb_cyc_in = 1'b0;
    wb_stb_in = 1'b0;
    wb_we_in = 1'b0;
    wb_adr_in = 20'h0;
    wb_sel_in = 4'hF;
    wb_dat_in = 32'h0;
    celldrop_evt_in = 5'h00;
    unaligned_evt_in = 7'h00;
    misalign_evt_in = 5'h00;
    fifo_wr_zero_in = 8'h00;
    fifo_rd_ptr_in = 32'h0;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_cell();
    t_sonet();
    t_near();
    t_irq();
    end_of_test();
  end
endmodule : test_lgas_top

bind lgas_top lgas_top_sva chk_i (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .sonet_mode_out(sonet_mode_out),
  .irq_out(irq_out));
`default_nettype wire
